// ===== src/cct_consts.svh
// Constants for the capture/compare timer: offsets, field positions, reset values
`ifndef CCT_CONSTS_SVH
`define CCT_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CCT_OFS_MODE     8'h00
`define CCT_OFS_CAPCTRL  8'h04
`define CCT_OFS_PRESC    8'h08
`define CCT_OFS_EDGE     8'h0C
`define CCT_OFS_COUNT    8'h10
`define CCT_OFS_CCA      8'h14
`define CCT_OFS_CCB      8'h18
`define CCT_OFS_STATUS   8'h1C
`define CCT_OFS_MASK     8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CCT_MODE_LO      2
`define CCT_MODE_HI      3
`define CCT_CC_A_CMP     0
`define CCT_CC_A_REV     1
`define CCT_CC_B_CMP     2
`define CCT_ST_A         0
`define CCT_ST_B         1
`define CCT_ST_OVF       2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CCT_RST_16       16'h0000
`define CCT_RST_4        4'h0
`define CCT_RST_3        3'h0
`define CCT_RST_2        2'h0

`endif

// ===== src/cct_pkg.sv
// Types shared by the capture/compare timer modules
package cct_pkg;
  // Edge selection for a trigger pin
  typedef enum logic [1:0] {
    CCT_EDGE_FALL = 2'h0,
    CCT_EDGE_RISE = 2'h1,
    CCT_EDGE_NONE = 2'h2,
    CCT_EDGE_BOTH = 2'h3
  } cct_edge_e;
  typedef enum logic [1:0] {CCT_ST_STOP, CCT_ST_RUN} cct_run_e;
endpackage : cct_pkg

// ===== src/cct_edge_if.sv
// Interface between an edge detector and the timer core
`timescale 1ns/100ps
interface cct_edge_if;
  logic                 pin_sync;
  logic                 valid_edge;
  cct_pkg::cct_edge_e   sel;
  logic                 enable;
  logic                 first_start;
  modport det  (input sel, input enable, input first_start, input pin_sync, output valid_edge);
  modport core (output sel, output enable, output first_start, output pin_sync, input valid_edge);
endinterface : cct_edge_if

// ===== src/cct_edge_det.sv
// Trigger pin edge detector with pulse-width qualification on the count clock
`timescale 1ns/100ps
`include "cct_consts.svh"
module cct_edge_det (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic cnt_tick,
  cct_edge_if.det   eif
);
  logic       prev_ff;
  logic       nxt_prev;
  logic [1:0] stab_ff;
  logic [1:0] nxt_stab;
  logic       lvl_ff;
  logic       nxt_lvl;
  logic       en_d_ff;
  logic       valid_ff;
  wire        rise_w;
  wire        fall_w;
  wire        en_rise_w;
  wire        sel_hit_w;

  // ----------------------------------------------------------------------------
  // Filter: level must hold for two count ticks to be accepted
  // ----------------------------------------------------------------------------
  assign nxt_prev = eif.pin_sync;
  assign nxt_stab = (eif.pin_sync != prev_ff) ? 2'h0 :
                    (cnt_tick && stab_ff != 2'h2) ? stab_ff + 2'h1 : stab_ff;
  assign nxt_lvl  = (stab_ff == 2'h2) ? prev_ff : lvl_ff;
  assign rise_w   = nxt_lvl & ~lvl_ff;
  assign fall_w   = ~nxt_lvl & lvl_ff;
  assign en_rise_w = eif.enable & ~en_d_ff & eif.first_start & eif.pin_sync;
  assign sel_hit_w = (eif.sel == cct_pkg::CCT_EDGE_RISE && (rise_w || en_rise_w)) ||
                     (eif.sel == cct_pkg::CCT_EDGE_FALL && fall_w) ||
                     (eif.sel == cct_pkg::CCT_EDGE_BOTH && (rise_w || fall_w || en_rise_w));
  assign eif.valid_edge = valid_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_ff  <= 1'b0;
      stab_ff  <= `CCT_RST_2;
      lvl_ff   <= 1'b0;
      en_d_ff  <= 1'b0;
      valid_ff <= 1'b0;
    end else begin
      prev_ff  <= nxt_prev;
      stab_ff  <= nxt_stab;
      lvl_ff   <= eif.enable ? nxt_lvl : eif.pin_sync;
      en_d_ff  <= eif.enable;
      valid_ff <= eif.enable & sel_hit_w;
    end
  end
endmodule : cct_edge_det

// ===== src/cct_timer.sv
// 16-bit timer counting prescaled clocks, with two capture/compare registers
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`include "cct_consts.svh"
module cct_timer (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        trigger_in_a,
  input  wire logic        shared_port_pin_in,
  output logic             shared_port_pin_out,
  output logic             shared_port_pin_oe,
  output logic             irq
);
  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [3:0]  timer_mode_ctrl_ff;
  logic [3:0]  capcmp_ctrl_ff;
  logic [2:0]  prescaler_sel_ff;
  logic [3:0]  edge_sel_ff;
  logic [15:0] counter_value_ff;
  logic [15:0] capcmp_a_ff;
  logic [15:0] capcmp_b_ff;
  logic [2:0]  status_ff;
  logic [2:0]  mask_ff;
  logic [31:0] rdata_ff;
  logic        irq_ff;
  logic        out_ff;
  logic        out_oe_ff;
  logic        started_ff;
  logic [7:0]  div_ff;
  logic [1:0]  sync_a_ff;
  logic [1:0]  sync_b_ff;

  // Software-selected function of the shared pin: 1 = timer output
  wire         pin_is_out_w;
  wire         run_w;
  wire         cnt_tick_w;
  wire [7:0]   nxt_div;
  wire [15:0]  nxt_counter_value;
  wire         wr_mode_w;
  wire         wr_capctrl_w;
  wire         wr_presc_w;
  wire         wr_edge_w;
  wire         wr_cca_w;
  wire         wr_ccb_w;
  wire         wr_status_w;
  wire         wr_mask_w;
  wire         a_cmp_w;
  wire         a_rev_w;
  wire         b_cmp_w;
  wire         edge_a_w;
  wire         edge_b_w;
  wire         cap_a_w;
  wire         cap_b_w;
  wire         match_a_w;
  wire         match_b_w;
  wire         ovf_w;
  wire [2:0]   ev_w;
  wire [2:0]   nxt_status;
  wire [31:0]  nxt_rdata;
  wire         nxt_out;

  cct_edge_if eif_a ();
  cct_edge_if eif_b ();

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  assign wr_mode_w    = wr && addr == `CCT_OFS_MODE;
  assign wr_capctrl_w = wr && addr == `CCT_OFS_CAPCTRL;
  assign wr_presc_w   = wr && addr == `CCT_OFS_PRESC;
  assign wr_edge_w    = wr && addr == `CCT_OFS_EDGE;
  assign wr_cca_w     = wr && addr == `CCT_OFS_CCA;
  assign wr_ccb_w     = wr && addr == `CCT_OFS_CCB;
  assign wr_status_w  = wr && addr == `CCT_OFS_STATUS;
  assign wr_mask_w    = wr && addr == `CCT_OFS_MASK;

  assign run_w = timer_mode_ctrl_ff[`CCT_MODE_HI:`CCT_MODE_LO] != 2'h0;
  assign pin_is_out_w = timer_mode_ctrl_ff[0];
  assign a_cmp_w = capcmp_ctrl_ff[`CCT_CC_A_CMP];
  assign a_rev_w = capcmp_ctrl_ff[`CCT_CC_A_REV];
  assign b_cmp_w = capcmp_ctrl_ff[`CCT_CC_B_CMP];

  // ----------------------------------------------------------------------------
  // Prescaler: count tick every 2^sel clocks
  // ----------------------------------------------------------------------------
  assign nxt_div    = run_w ? div_ff + 8'h01 : 8'h00;
  assign cnt_tick_w = run_w && ((div_ff & ((8'h01 << prescaler_sel_ff) - 8'h01)) == 8'h00);
  assign nxt_counter_value = cnt_tick_w ? counter_value_ff + 16'h0001 : counter_value_ff;
  assign ovf_w = cnt_tick_w && counter_value_ff == 16'hFFFF;

  // ----------------------------------------------------------------------------
  // Trigger edges
  // ----------------------------------------------------------------------------
  assign eif_a.pin_sync    = sync_a_ff[1];
  assign eif_a.sel         = cct_pkg::cct_edge_e'(edge_sel_ff[1:0]);
  assign eif_a.enable      = run_w;
  assign eif_a.first_start = ~started_ff;
  assign eif_b.pin_sync    = sync_b_ff[1] & ~pin_is_out_w;
  assign eif_b.sel         = cct_pkg::cct_edge_e'(edge_sel_ff[3:2]);
  assign eif_b.enable      = run_w & ~pin_is_out_w;
  assign eif_b.first_start = ~started_ff;

  cct_edge_det u_det_a (.ref_clk(ref_clk), .rst(rst), .cnt_tick(cnt_tick_w), .eif(eif_a));
  cct_edge_det u_det_b (.ref_clk(ref_clk), .rst(rst), .cnt_tick(cnt_tick_w), .eif(eif_b));

  assign edge_a_w = eif_a.valid_edge;
  assign edge_b_w = eif_b.valid_edge;
  // compare mode ignores triggers; reverse phase captures A from pin a
  assign cap_a_w  = run_w && !a_cmp_w && (a_rev_w ? edge_a_w : edge_b_w);
  // compare mode ignores triggers; only pin edges capture into B
  assign cap_b_w  = run_w && !b_cmp_w && edge_a_w && !a_rev_w;
  assign match_a_w = cnt_tick_w && a_cmp_w && nxt_counter_value == capcmp_a_ff;
  assign match_b_w = cnt_tick_w && b_cmp_w && nxt_counter_value == capcmp_b_ff;

  // ----------------------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------------------
  // reverse phase: irq from pin b edge, none from capture
  assign ev_w[`CCT_ST_A]   = a_rev_w ? (run_w && !a_cmp_w && edge_b_w) : (cap_a_w || match_a_w);
  assign ev_w[`CCT_ST_B]   = cap_b_w || match_b_w;
  assign ev_w[`CCT_ST_OVF] = ovf_w;
  // Set wins over write-one-clear
  assign nxt_status = (status_ff & ~(wr_status_w ? wdata[2:0] : 3'h0)) | ev_w;
  assign nxt_out    = match_a_w ? ~out_ff : out_ff;

  assign nxt_rdata =
    (addr == `CCT_OFS_MODE)    ? {28'h0000000, timer_mode_ctrl_ff} :
    (addr == `CCT_OFS_CAPCTRL) ? {28'h0000000, capcmp_ctrl_ff} :
    (addr == `CCT_OFS_PRESC)   ? {29'h0000000, prescaler_sel_ff} :
    (addr == `CCT_OFS_EDGE)    ? {28'h0000000, edge_sel_ff} :
    (addr == `CCT_OFS_COUNT)   ? {16'h0000, counter_value_ff} :
    (addr == `CCT_OFS_CCA)     ? {16'h0000, capcmp_a_ff} :
    (addr == `CCT_OFS_CCB)     ? {16'h0000, capcmp_b_ff} :
    (addr == `CCT_OFS_STATUS)  ? {29'h0000000, status_ff} :
    (addr == `CCT_OFS_MASK)    ? {29'h0000000, mask_ff} : 32'h00000000;

  // ----------------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_mode_ctrl_ff <= `CCT_RST_4;
      capcmp_ctrl_ff     <= `CCT_RST_4;
      prescaler_sel_ff   <= `CCT_RST_3;
      edge_sel_ff        <= `CCT_RST_4;
      mask_ff            <= `CCT_RST_3;
      status_ff          <= `CCT_RST_3;
      started_ff         <= 1'b0;
      sync_a_ff          <= `CCT_RST_2;
      sync_b_ff          <= `CCT_RST_2;
      div_ff             <= 8'h00;
    end else begin
      if (wr_mode_w) timer_mode_ctrl_ff <= wdata[3:0];
      if (wr_capctrl_w) capcmp_ctrl_ff <= wdata[3:0];
      if (wr_presc_w) prescaler_sel_ff <= wdata[2:0];
      if (wr_edge_w) edge_sel_ff <= wdata[3:0];
      if (wr_mask_w) mask_ff <= wdata[2:0];
      status_ff  <= nxt_status;
      started_ff <= started_ff | run_w;
      sync_a_ff  <= {sync_a_ff[0], trigger_in_a};
      sync_b_ff  <= {sync_b_ff[0], shared_port_pin_in};
      div_ff     <= nxt_div;
    end
  end

  // ----------------------------------------------------------------------------
  // Counter and capture/compare data
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      counter_value_ff <= `CCT_RST_16;
      capcmp_a_ff      <= `CCT_RST_16;
      capcmp_b_ff      <= `CCT_RST_16;
    end else begin
      counter_value_ff <= run_w ? nxt_counter_value : `CCT_RST_16;
      // a capture in the stop cycle stores the live count; stop keeps data
      if (cap_a_w) capcmp_a_ff <= counter_value_ff;
      else if (wr_cca_w) capcmp_a_ff <= wdata[15:0];
      if (cap_b_w) capcmp_b_ff <= counter_value_ff;
      else if (wr_ccb_w) capcmp_b_ff <= wdata[15:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff  <= 32'h00000000;
      irq_ff    <= 1'b0;
      out_ff    <= 1'b0;
      out_oe_ff <= 1'b0;
    end else begin
      rdata_ff  <= rd ? nxt_rdata : 32'h00000000;
      irq_ff    <= |(nxt_status & mask_ff);
      out_ff    <= run_w ? nxt_out : 1'b0;
      out_oe_ff <= pin_is_out_w;
    end
  end

  assign rdata               = rdata_ff;
  assign irq                 = irq_ff;
  assign shared_port_pin_out = out_ff;
  assign shared_port_pin_oe  = out_oe_ff;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  sequence s_cap_a;
    cap_a_w;
  endsequence
  sequence s_hold_a;
    ##1 capcmp_a_ff == $past(counter_value_ff);
  endsequence
  sequence s_cap_b;
    cap_b_w;
  endsequence
  sequence s_hold_b;
    ##1 capcmp_b_ff == $past(counter_value_ff);
  endsequence

  // ----------------------------------------------------------------------------
  // Capture and hold
  // ----------------------------------------------------------------------------
  a_cap_a_load: assert property (@(posedge ref_clk) disable iff (rst)
    s_cap_a |-> s_hold_a)
    else $error("capcmp_a did not load counter");
  a_cap_b_load: assert property (@(posedge ref_clk) disable iff (rst)
    s_cap_b |-> s_hold_b)
    else $error("capcmp_b did not load counter");
  a_cmp_a_ignore: assert property (@(posedge ref_clk) disable iff (rst)
    a_cmp_w && !wr_cca_w |=> $stable(capcmp_a_ff))
    else $error("capcmp_a changed in compare mode");
  a_cmp_b_ignore: assert property (@(posedge ref_clk) disable iff (rst)
    b_cmp_w && !wr_ccb_w |=> $stable(capcmp_b_ff))
    else $error("capcmp_b changed in compare mode");
  a_read_no_cap: assert property (@(posedge ref_clk) disable iff (rst)
    rd && !edge_a_w && !wr_ccb_w |=> $stable(capcmp_b_ff))
    else $error("read captured into capcmp_b");
  a_hold_a_stop: assert property (@(posedge ref_clk) disable iff (rst)
    !cap_a_w && !wr_cca_w |=> $stable(capcmp_a_ff))
    else $error("capcmp_a lost its value");
  a_stop_cap: assert property (@(posedge ref_clk) disable iff (rst)
    wr_mode_w && wdata[`CCT_MODE_HI:`CCT_MODE_LO] == 2'h0 |=> !cap_a_w && !cap_b_w)
    else $error("capture after stop");
  a_stop_lands: assert property (@(posedge ref_clk) disable iff (rst)
    cap_a_w && wr_mode_w && wdata[`CCT_MODE_HI:`CCT_MODE_LO] == 2'h0 |=> !run_w)
    else $error("stop lost in capture cycle");
  a_rev_no_cap: assert property (@(posedge ref_clk) disable iff (rst)
    a_rev_w && edge_b_w && !edge_a_w && !wr_cca_w |=> $stable(capcmp_a_ff))
    else $error("pin b edge captured in reverse phase");
  a_first_edge: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(run_w) && started_ff |=> !edge_a_w && !edge_b_w)
    else $error("level-as-edge after restart");

  // ----------------------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------------------
  a_rev_no_irq: assert property (@(posedge ref_clk) disable iff (rst)
    a_rev_w && cap_a_w && !edge_b_w && !status_ff[0] |=> !status_ff[0])
    else $error("reverse capture raised irq");
  a_rev_ext_irq: assert property (@(posedge ref_clk) disable iff (rst)
    a_rev_w && !a_cmp_w && run_w && edge_b_w
    |=> status_ff[0] && ($stable(capcmp_a_ff) || $past(edge_a_w) || $past(wr_cca_w)))
    else $error("reverse-phase pin b edge not handled");
  a_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
    ev_w != 3'h0 |=> (status_ff & $past(ev_w)) == $past(ev_w))
    else $error("status event lost");
  a_clear_one: assert property (@(posedge ref_clk) disable iff (rst)
    wr_status_w && wdata[`CCT_ST_A] && !ev_w[`CCT_ST_A] |=> !status_ff[`CCT_ST_A])
    else $error("status bit not cleared");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    (|(status_ff & mask_ff)) && !wr_status_w |=> irq)
    else $error("irq low with unmasked status");
  a_irq_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (status_ff & mask_ff) == 3'h0 && ev_w == 3'h0 |=> !irq)
    else $error("irq high with no unmasked status");

  // ----------------------------------------------------------------------------
  // Shared pin
  // ----------------------------------------------------------------------------
  a_pin_excl: assert property (@(posedge ref_clk) disable iff (rst)
    shared_port_pin_oe |-> !edge_b_w ##1 1'b1)
    else $error("pin b edge while pin drives");
  a_oe_follow: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> shared_port_pin_oe == $past(pin_is_out_w))
    else $error("pin enable does not follow mode");

  // ----------------------------------------------------------------------------
  // Counter and mode
  // ----------------------------------------------------------------------------
  a_run_count: assert property (@(posedge ref_clk) disable iff (rst)
    !run_w |=> counter_value_ff == 16'h0000)
    else $error("counter ran while stopped");
  a_run_start: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(run_w) |-> counter_value_ff == 16'h0000)
    else $error("counter not zero at start");
  a_mode_start: assert property (@(posedge ref_clk) disable iff (rst)
    wr_mode_w && wdata[`CCT_MODE_HI:`CCT_MODE_LO] != 2'h0 |=> run_w)
    else $error("timer did not start");
  a_mode_stop: assert property (@(posedge ref_clk) disable iff (rst)
    wr_mode_w && wdata[`CCT_MODE_HI:`CCT_MODE_LO] == 2'h0 |=> !run_w)
    else $error("timer did not stop");
  a_out_stop: assert property (@(posedge ref_clk) disable iff (rst)
    !run_w |=> !shared_port_pin_out)
    else $error("timer output high while stopped");
  a_cnt_step: assert property (@(posedge ref_clk) disable iff (rst)
    cnt_tick_w && counter_value_ff != 16'hFFFF
    |=> counter_value_ff == $past(counter_value_ff) + 16'h0001)
    else $error("counter did not step by one");
  a_cnt_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    run_w && cnt_tick_w && counter_value_ff == 16'hFFFF |=> counter_value_ff == 16'h0000)
    else $error("counter did not wrap");
endmodule : cct_timer

// ===== testbench/cct_pin_model.sv
// External trigger sources that drive the two capture pins
`timescale 1ns/100ps
module cct_pin_model (
  input  wire logic ref_clk,
  input  wire logic pin_oe,
  input  wire logic pin_out,
  output logic      trig_a,
  output logic      trig_b_pin
);
  logic drv_b;

  initial begin
    trig_a = 1'b0;
    drv_b  = 1'b0;
  end

  // one pin function
  // The timer output owns the shared wire while it is enabled
  assign trig_b_pin = pin_oe ? pin_out : drv_b;

  task automatic set_b(input logic v);
    @(posedge ref_clk);
    drv_b <= v;
  endtask : set_b

  // minimum pulse width
  // Pulses span well over two count ticks so capture is guaranteed
  task automatic pulse(input logic on_b, input int unsigned len);
    @(posedge ref_clk);
    if (on_b) begin
      drv_b <= 1'b1;
    end else begin
      trig_a <= 1'b1;
    end
    repeat (len) @(posedge ref_clk);
    drv_b  <= 1'b0;
    trig_a <= 1'b0;
  endtask : pulse
endmodule : cct_pin_model

// ===== testbench/cct_timer_tb.sv
// Self-checking bench for the capture/compare timer
`timescale 1ns/100ps
`include "cct_consts.svh"
module cct_timer_tb;
  logic        ref_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [31:0] rdata;
  logic        trig_a;
  logic        pin_in;
  logic        pin_out;
  logic        pin_oe;
  logic        irq;
  int          err_count = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  logic [31:0] lo;
  logic [31:0] hi;
  logic [31:0] d;
  logic [31:0] cap_a;

  always #12.5 ref_clk = ~ref_clk;

  cct_timer u_cct_timer (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trigger_in_a(trig_a), .shared_port_pin_in(pin_in), .shared_port_pin_out(pin_out),
    .shared_port_pin_oe(pin_oe), .irq(irq));

  cct_pin_model u_cct_pin_model (.ref_clk(ref_clk), .pin_oe(pin_oe), .pin_out(pin_out),
    .trig_a(trig_a), .trig_b_pin(pin_in));

  // ----------------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(name, exp, v);
  endtask : chk_reg

  task automatic chk_rng(input string name, input logic [31:0] l, input logic [31:0] h, input logic [31:0] got);
    tests_run++;
    if (((got >= l) && (got <= h)) !== 1'b1) begin
      err_count++;
      $display("Error %s expected %h to %h seen %h", name, l, h, got);
    end
  endtask : chk_rng

  // Capture window: count before the pulse, pulse, count after it settles
  task automatic cap_pulse(input logic on_b);
    rd_reg(`CCT_OFS_COUNT, lo);
    u_cct_pin_model.pulse(on_b, 8);
    repeat (10) @(posedge ref_clk);
    rd_reg(`CCT_OFS_COUNT, hi);
  endtask : cap_pulse

  task automatic summarize();
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    chk_reg("count", `CCT_OFS_COUNT, 32'h0);
    chk_reg("status", `CCT_OFS_STATUS, 32'h0);
    chk_reg("unmapped", 8'h40, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr_reg(`CCT_OFS_MODE, 32'h00000001);
    repeat (2) @(posedge ref_clk);
    chk("pin_oe", 32'h1, {31'h0, pin_oe});
    wr_reg(`CCT_OFS_MODE, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("pin_oe", 32'h0, {31'h0, pin_oe});
  endtask : t_reset

  task automatic t_first_start();
    wr_reg(`CCT_OFS_EDGE, 32'h00000005);
    wr_reg(`CCT_OFS_MASK, 32'h00000001);
    u_cct_pin_model.set_b(1'b1);
    repeat (4) @(posedge ref_clk);
    wr_reg(`CCT_OFS_MODE, 32'h00000004);
    repeat (12) @(posedge ref_clk);
    rd_reg(`CCT_OFS_COUNT, hi);
    chk_reg("status", `CCT_OFS_STATUS, 32'h00000001);
    rd_reg(`CCT_OFS_CCA, cap_a);
    chk_rng("capcmp_a", 32'h0, hi, cap_a);
    chk("irq", 32'h1, {31'h0, irq});
    u_cct_pin_model.set_b(1'b0);
    wr_reg(`CCT_OFS_STATUS, 32'h00000001);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
  endtask : t_first_start

  task automatic t_count();
    rd_reg(`CCT_OFS_COUNT, lo);
    repeat (10) @(posedge ref_clk);
    rd_reg(`CCT_OFS_COUNT, hi);
    chk("count_step", 32'h0000000C, {16'h0, hi[15:0] - lo[15:0]});
    chk_reg("capcmp_b", `CCT_OFS_CCB, 32'h0);
    wr_reg(`CCT_OFS_MODE, 32'h0);
    repeat (5) @(posedge ref_clk);
    chk_reg("count", `CCT_OFS_COUNT, 32'h0);
    chk_reg("capcmp_a", `CCT_OFS_CCA, cap_a);
  endtask : t_count

  task automatic t_compare();
    wr_reg(`CCT_OFS_MODE, 32'h0);
    wr_reg(`CCT_OFS_CAPCTRL, 32'h00000005);
    chk_reg("capcmp_a", `CCT_OFS_CCA, cap_a);
    wr_reg(`CCT_OFS_CCA, 32'h00001234);
    wr_reg(`CCT_OFS_CCB, 32'h00000ABC);
    wr_reg(`CCT_OFS_MODE, 32'h00000004);
    cap_pulse(1'b1);
    cap_pulse(1'b0);
    chk_reg("capcmp_a", `CCT_OFS_CCA, 32'h00001234);
    chk_reg("capcmp_b", `CCT_OFS_CCB, 32'h00000ABC);
    chk_reg("status", `CCT_OFS_STATUS, 32'h0);
    wr_reg(`CCT_OFS_MODE, 32'h0);
  endtask : t_compare

  task automatic t_normal_b();
    wr_reg(`CCT_OFS_CAPCTRL, 32'h0);
    wr_reg(`CCT_OFS_MODE, 32'h00000004);
    cap_pulse(1'b0);
    rd_reg(`CCT_OFS_CCB, d);
    chk_rng("capcmp_b", lo, hi, d);
    chk_reg("status", `CCT_OFS_STATUS, 32'h00000002);
    chk("irq", 32'h0, {31'h0, irq});
    wr_reg(`CCT_OFS_STATUS, 32'h00000002);
    wr_reg(`CCT_OFS_MODE, 32'h0);
  endtask : t_normal_b

  task automatic t_reverse();
    wr_reg(`CCT_OFS_CAPCTRL, 32'h00000002);
    wr_reg(`CCT_OFS_MODE, 32'h00000004);
    cap_pulse(1'b0);
    rd_reg(`CCT_OFS_CCA, cap_a);
    chk_rng("capcmp_a", lo, hi, cap_a);
    chk_reg("status", `CCT_OFS_STATUS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    cap_pulse(1'b1);
    chk_reg("status", `CCT_OFS_STATUS, 32'h00000001);
    chk_reg("capcmp_a", `CCT_OFS_CCA, cap_a);
    chk("irq", 32'h1, {31'h0, irq});
    wr_reg(`CCT_OFS_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    wr_reg(`CCT_OFS_STATUS, 32'h00000001);
    wr_reg(`CCT_OFS_MODE, 32'h0);
  endtask : t_reverse

  // Compare match toggles the timer output on the shared pin, half-rate count
  task automatic t_out();
    wr_reg(`CCT_OFS_CAPCTRL, 32'h00000001);
    wr_reg(`CCT_OFS_CCA, 32'h00000010);
    wr_reg(`CCT_OFS_PRESC, 32'h00000001);
    wr_reg(`CCT_OFS_MODE, 32'h00000005);
    rd_reg(`CCT_OFS_COUNT, lo);
    repeat (10) @(posedge ref_clk);
    rd_reg(`CCT_OFS_COUNT, hi);
    chk("count_half", 32'h00000006, {16'h0, hi[15:0] - lo[15:0]});
    chk("pin_out", 32'h0, {31'h0, pin_out});
    repeat (30) @(posedge ref_clk);
    chk("pin_out", 32'h1, {31'h0, pin_out});
    chk("pin_oe", 32'h1, {31'h0, pin_oe});
    chk_reg("status", `CCT_OFS_STATUS, 32'h00000001);
    wr_reg(`CCT_OFS_STATUS, 32'h00000001);
    wr_reg(`CCT_OFS_MODE, 32'h0);
    wr_reg(`CCT_OFS_PRESC, 32'h0);
    chk("pin_out", 32'h0, {31'h0, pin_out});
  endtask : t_out

  task automatic t_reenable();
    wr_reg(`CCT_OFS_CAPCTRL, 32'h0);
    u_cct_pin_model.set_b(1'b1);
    repeat (4) @(posedge ref_clk);
    wr_reg(`CCT_OFS_MODE, 32'h00000004);
    repeat (12) @(posedge ref_clk);
    chk_reg("status", `CCT_OFS_STATUS, 32'h0);
    u_cct_pin_model.set_b(1'b0);
    wr_reg(`CCT_OFS_MODE, 32'h0);
  endtask : t_reenable

  // ----------------------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_first_start();
    t_count();
    t_compare();
    t_normal_b();
    t_reverse();
    t_out();
    t_reenable();
    summarize();
  end
endmodule : cct_timer_tb
